// *** psr_regs.vh ***
// Register offsets, field positions, reset values and timing figures of the
// boost-switch controller. Definitions only; included by psr_pfc_ctrl.v.
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ********************************
// Register offsets
// ********************************
`define PSR_A_CTRL     4'h0
`define PSR_A_FMIN     4'h1
`define PSR_A_FMAX     4'h2
`define PSR_A_FABS     4'h3
`define PSR_A_TOFF     4'h4
`define PSR_A_JIT      4'h5
`define PSR_A_VREF     4'h6
`define PSR_A_RC       4'h7
`define PSR_A_BURST    4'h8
`define PSR_A_RIPPLE   4'h9
`define PSR_A_RAMP     4'ha
`define PSR_A_CCM      4'hb
`define PSR_A_OCP      4'hc
`define PSR_A_STATUS   4'hd
`define PSR_A_AMP      4'he

// ********************************
// Control fields
// ********************************
`define PSR_C_EN       0
`define PSR_C_MODE_LO  1
`define PSR_C_MODE_HI  2
`define PSR_C_VALLEY   3
`define PSR_C_JIT      4
`define PSR_C_SS       5
`define PSR_C_SSTOP    6
`define PSR_MODE_MULTI 2'h0
`define PSR_MODE_QR    2'h1
`define PSR_MODE_FIXED 2'h2

// ********************************
// Reset values (periods in clock cycles)
// ********************************
`define PSR_RST_CTRL   16'h0008
`define PSR_RST_FMIN   16'h1388
`define PSR_RST_FMAX   16'h03e8
`define PSR_RST_FABS   16'h0320
`define PSR_RST_TOFF   16'h0028
`define PSR_RST_JIT    16'h1010
`define PSR_RST_VREF   12'h9c4
`define PSR_RST_RC     4'h4
`define PSR_RST_BURST  16'h0820
`define PSR_RST_RIPPLE 12'h040
`define PSR_RST_RAMP   16'h1010
`define PSR_RST_CCM    12'h400
`define PSR_RST_OCP    12'hf00
`define PSR_RST_AMP    12'h100

// ********************************
// Timing
// ********************************
`define PSR_CLK_MHZ         200
`define PSR_VALLEY_TO_NS    7000
`define PSR_VALLEY_TO_CYC   (((`PSR_VALLEY_TO_NS) * (`PSR_CLK_MHZ)) / 1000)
`define PSR_TON_MIN         16'h0001
`define PSR_FULL            12'hfff
`define PSR_FRAC            12
`endif

// *** psr_pfc_ctrl.v ***
// Digital control of the boost power-factor switch: frequency curve, on-time,
// conduction modes, jitter, start-up shaping, voltage loop and burst handling.
// Assumes converter samples arrive on clk; comparator pins are asynchronous.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "psr_regs.vh"

module psr_pfc_ctrl #(
  parameter LOOP_DIV = 200
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [11:0] boost_voltage_sense,
  input  wire [11:0] switch_current_sense,
  input  wire [11:0] sine_ref,
  input  wire        demag_pin,
  input  wire        switch_drain_sense,
  input  wire        chip_supply_pin,
  input  wire        llc_burst,
  input  wire        llc_switching,
  input  wire [7:0]  llc_duty,
  output reg         gate_drive,
  output reg         supply_source_en,
  output reg         burst_state
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ON   = 4'h2;
  localparam [3:0] ST_OFF  = 4'h4;
  localparam [3:0] ST_WAIT = 4'h8;
  localparam integer VTO_FULL = `PSR_VALLEY_TO_CYC;
  localparam [15:0] VTO_CYC  = VTO_FULL[15:0];
  localparam [15:0] LOOP_N   = LOOP_DIV[15:0];

  // Scales a 16-bit value by a 12-bit fraction of full scale.
  function [15:0] scale;
    input [15:0] a;
    input [11:0] f;
    reg   [27:0] p;
    begin
      p = a * f;
      scale = p[27:`PSR_FRAC];
    end
  endfunction

  // ********************************
  // Registers
  // ********************************
  reg [15:0] ctrl_r, fmin_r, fmax_r, fabs_r, toff_r, jit_cfg_r, burst_cfg_r, ramp_cfg_r;
  reg [11:0] vref_r, ripple_r, ccm_r, ocp_r;
  reg [3:0]  rc_r;

  wire       en_w     = ctrl_r[`PSR_C_EN];
  wire [1:0] mode_w   = ctrl_r[`PSR_C_MODE_HI:`PSR_C_MODE_LO];
  wire [7:0] jit_amp  = jit_cfg_r[7:0];
  wire [7:0] jit_rate = jit_cfg_r[15:8];
  wire [7:0] b_entry  = burst_cfg_r[7:0];
  wire [7:0] b_hyst   = burst_cfg_r[15:8];

  reg [3:0]  st_r;
  reg [11:0] amp_r, target_r, ifilt_r, ramp_r;
  reg        nonop_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r      <= `PSR_RST_CTRL;
      fmin_r      <= `PSR_RST_FMIN;
      fmax_r      <= `PSR_RST_FMAX;
      fabs_r      <= `PSR_RST_FABS;
      toff_r      <= `PSR_RST_TOFF;
      jit_cfg_r   <= `PSR_RST_JIT;
      vref_r      <= `PSR_RST_VREF;
      rc_r        <= `PSR_RST_RC;
      burst_cfg_r <= `PSR_RST_BURST;
      ripple_r    <= `PSR_RST_RIPPLE;
      ramp_cfg_r  <= `PSR_RST_RAMP;
      ccm_r       <= `PSR_RST_CCM;
      ocp_r       <= `PSR_RST_OCP;
    end else if (wr) begin
      if (addr == `PSR_A_CTRL) begin
        ctrl_r <= wdata;
      end else if (addr == `PSR_A_FMIN) begin
        fmin_r <= wdata;
      end else if (addr == `PSR_A_FMAX) begin
        fmax_r <= wdata;
      end else if (addr == `PSR_A_FABS) begin
        fabs_r <= wdata;
      end else if (addr == `PSR_A_TOFF) begin
        toff_r <= wdata;
      end else if (addr == `PSR_A_JIT) begin
        jit_cfg_r <= wdata;
      end else if (addr == `PSR_A_VREF) begin
        vref_r <= wdata[11:0];
      end else if (addr == `PSR_A_RC) begin
        rc_r <= wdata[3:0];
      end else if (addr == `PSR_A_BURST) begin
        burst_cfg_r <= wdata;
      end else if (addr == `PSR_A_RIPPLE) begin
        ripple_r <= wdata[11:0];
      end else if (addr == `PSR_A_RAMP) begin
        ramp_cfg_r <= wdata;
      end else if (addr == `PSR_A_CCM) begin
        ccm_r <= wdata[11:0];
      end else if (addr == `PSR_A_OCP) begin
        ocp_r <= wdata[11:0];
      end
    end
  end

  // Unmapped addresses read as zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `PSR_A_CTRL) begin
        rdata <= ctrl_r;
      end else if (addr == `PSR_A_FMIN) begin
        rdata <= fmin_r;
      end else if (addr == `PSR_A_FMAX) begin
        rdata <= fmax_r;
      end else if (addr == `PSR_A_FABS) begin
        rdata <= fabs_r;
      end else if (addr == `PSR_A_TOFF) begin
        rdata <= toff_r;
      end else if (addr == `PSR_A_JIT) begin
        rdata <= jit_cfg_r;
      end else if (addr == `PSR_A_VREF) begin
        rdata <= {4'h0, vref_r};
      end else if (addr == `PSR_A_RC) begin
        rdata <= {12'h000, rc_r};
      end else if (addr == `PSR_A_BURST) begin
        rdata <= burst_cfg_r;
      end else if (addr == `PSR_A_RIPPLE) begin
        rdata <= {4'h0, ripple_r};
      end else if (addr == `PSR_A_RAMP) begin
        rdata <= ramp_cfg_r;
      end else if (addr == `PSR_A_CCM) begin
        rdata <= {4'h0, ccm_r};
      end else if (addr == `PSR_A_OCP) begin
        rdata <= {4'h0, ocp_r};
      end else if (addr == `PSR_A_STATUS) begin
        rdata <= {6'h00, nonop_r, burst_state, gate_drive, 3'h0, st_r};
      end else if (addr == `PSR_A_AMP) begin
        rdata <= {4'h0, amp_r};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ********************************
  // Pin synchronisers
  // ********************************
  // A change is accepted only when the second and third stages agree.
  reg [2:0] demag_s, valley_s, low_s;
  reg       demag_q, valley_q, low_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      demag_s  <= 3'h0;
      valley_s <= 3'h0;
      low_s    <= 3'h0;
      demag_q  <= 1'b0;
      valley_q <= 1'b0;
      low_q    <= 1'b0;
    end else begin
      demag_s  <= {demag_s[1:0], demag_pin};
      valley_s <= {valley_s[1:0], switch_drain_sense};
      low_s    <= {low_s[1:0], chip_supply_pin};
      if (demag_s[1] == demag_s[2]) demag_q <= demag_s[2];
      if (valley_s[1] == valley_s[2]) valley_q <= valley_s[2];
      if (low_s[1] == low_s[2]) low_q <= low_s[2];
    end
  end

  // ********************************
  // Voltage loop, start-up curve, current filter
  // ********************************
  reg [15:0] loop_cnt_r;
  reg        started_r;
  wire       loop_tick = (loop_cnt_r == LOOP_N - 16'h0001);
  wire [11:0] tgt_gap  = vref_r - target_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_cnt_r <= 16'h0000;
      amp_r      <= `PSR_RST_AMP;
      target_r   <= 12'h000;
      started_r  <= 1'b0;
      ifilt_r    <= 12'h000;
    end else begin
      loop_cnt_r <= loop_tick ? 16'h0000 : loop_cnt_r + 16'h0001;
      ifilt_r <= ifilt_r + ((switch_current_sense - ifilt_r) >>> 2);
      if (ifilt_r > switch_current_sense) begin
        ifilt_r <= ifilt_r - ((ifilt_r - switch_current_sense) >> 2);
      end
      if (!en_w) begin
        started_r <= 1'b0;
        amp_r     <= `PSR_RST_AMP;
      end else if (!started_r) begin
        // The curve starts from the present output, so no step is applied.
        started_r <= 1'b1;
        target_r  <= boost_voltage_sense;
        amp_r     <= 12'h000;
      end else if (loop_tick) begin
        if (target_r < vref_r) begin
          target_r <= target_r + ((tgt_gap >> rc_r) | 12'h001);
        end
        if (boost_voltage_sense < target_r && amp_r != `PSR_FULL) begin
          amp_r <= amp_r + 12'h001;
        end else if (boost_voltage_sense > target_r && amp_r != 12'h000) begin
          amp_r <= amp_r - 12'h001;
        end
      end
    end
  end

  // ********************************
  // Burst handling
  // ********************************
  reg        bsw_r;
  wire [8:0] exit_lvl  = {1'b0, b_entry} + {1'b0, b_hyst};
  wire       at_reg    = boost_voltage_sense >= vref_r;
  wire       below_rip = {1'b0, boost_voltage_sense} < ({1'b0, vref_r} - {1'b0, ripple_r});
  wire       want      = burst_state ? bsw_r : 1'b1;
  wire [11:0] ss_step  = {4'h0, ramp_cfg_r[7:0]};
  wire [11:0] sp_step  = {4'h0, ramp_cfg_r[15:8]};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_state      <= 1'b0;
      bsw_r            <= 1'b0;
      nonop_r          <= 1'b0;
      supply_source_en <= 1'b0;
      ramp_r           <= 12'h000;
    end else begin
      if (!burst_state && llc_burst && llc_duty < b_entry) begin
        burst_state <= 1'b1;
      end else if (burst_state && (!llc_burst || {1'b0, llc_duty} > exit_lvl)) begin
        burst_state <= 1'b0;
      end
      if (burst_state && (bsw_r || ramp_r != 12'h000) && low_q) begin
        bsw_r            <= 1'b0;
        nonop_r          <= 1'b1;
        supply_source_en <= 1'b1;
      end else if (nonop_r) begin
        // Supply recovered by the internal source; normal control resumes.
        if (!low_q) begin
          nonop_r          <= 1'b0;
          supply_source_en <= 1'b0;
        end
      end else if (!burst_state) begin
        bsw_r <= 1'b0;
      end else if (ripple_r == 12'h000) begin
        if (llc_switching) bsw_r <= 1'b1;
        else if (at_reg) bsw_r <= 1'b0;
      end else begin
        if (below_rip) bsw_r <= 1'b1;
        else if (at_reg) bsw_r <= 1'b0;
      end
      // The ramp scales the current at the start and end of each burst packet.
      if (nonop_r || !en_w) begin
        ramp_r <= 12'h000;
      end else if (!burst_state) begin
        ramp_r <= `PSR_FULL;
      end else if (want) begin
        if (!ctrl_r[`PSR_C_SS] || `PSR_FULL - ramp_r <= ss_step) ramp_r <= `PSR_FULL;
        else if (loop_tick) ramp_r <= ramp_r + ss_step;
      end else begin
        if (!ctrl_r[`PSR_C_SSTOP] || ramp_r <= sp_step) ramp_r <= 12'h000;
        else if (loop_tick) ramp_r <= ramp_r - sp_step;
      end
    end
  end

  // ********************************
  // Frequency curve, jitter and on-time
  // ********************************
  reg  [8:0]  jit_r;
  reg         jit_up_r;
  reg  [7:0]  jit_cnt_r;
  reg  [15:0] curve, per_w, ton_w;
  wire [15:0] amp_sc   = scale({4'h0, amp_r}, ramp_r);
  wire [11:0] amp_eff  = amp_sc[11:0];
  wire [15:0] dem_sc   = scale({4'h0, sine_ref}, amp_eff);
  wire [11:0] desired  = dem_sc[11:0];
  wire [15:0] span     = (fmin_r > fmax_r) ? fmin_r - fmax_r : 16'h0000;
  wire        jit_on   = ctrl_r[`PSR_C_JIT];

  always @* begin
    if (mode_w == `PSR_MODE_FIXED) curve = fmin_r;
    else curve = fmin_r - scale(span, desired);
    per_w = curve;
    if (jit_on) begin
      per_w = curve + {7'h00, jit_r} - {8'h00, jit_amp};
      if (curve < {8'h00, jit_amp}) per_w = curve;
    end
    if (per_w > fmin_r && mode_w != `PSR_MODE_FIXED) per_w = fmin_r;
    if (per_w < fmax_r) per_w = fmax_r;
    if (per_w < fabs_r) per_w = fabs_r;
    ton_w = scale(per_w, desired);
    if (ton_w < `PSR_TON_MIN) ton_w = `PSR_TON_MIN;
    if (per_w > toff_r && ton_w > per_w - toff_r) ton_w = per_w - toff_r;
  end

  // Triangle between zero and twice the amplitude, stepped at the set rate.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      jit_r     <= 9'h000;
      jit_up_r  <= 1'b1;
      jit_cnt_r <= 8'h00;
    end else if (loop_tick && jit_on) begin
      if (jit_cnt_r >= jit_rate) begin
        jit_cnt_r <= 8'h00;
        if (jit_up_r) begin
          if (jit_r >= {jit_amp, 1'b0}) jit_up_r <= 1'b0;
          else jit_r <= jit_r + 9'h001;
        end else begin
          if (jit_r == 9'h000) jit_up_r <= 1'b1;
          else jit_r <= jit_r - 9'h001;
        end
      end else begin
        jit_cnt_r <= jit_cnt_r + 8'h01;
      end
    end
  end

  // ********************************
  // Switching cycle
  // ********************************
  reg  [15:0] cnt_r, off_r, ton_r, per_r, to_r;
  reg         dmg_r, vprev_r;
  wire run  = en_w && !nonop_r && (want || ramp_r != 12'h000);
  wire go   = run && desired != 12'h000;
  wire wait_v = (mode_w == `PSR_MODE_QR) ||
                (mode_w == `PSR_MODE_MULTI && ctrl_r[`PSR_C_VALLEY] && desired < ccm_r);
  wire valley = dmg_r && valley_q && !vprev_r;
  wire vto    = dmg_r && to_r >= VTO_CYC - 16'h0001;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      gate_drive <= 1'b0;
      cnt_r      <= 16'h0000;
      off_r      <= 16'h0000;
      ton_r      <= 16'h0000;
      per_r      <= 16'h0000;
      to_r       <= 16'h0000;
      dmg_r      <= 1'b0;
      vprev_r    <= 1'b0;
    end else begin
      vprev_r <= valley_q;
      case (st_r)
        ST_IDLE: begin
          gate_drive <= 1'b0;
          if (go) begin
            st_r       <= ST_ON;
            gate_drive <= 1'b1;
            ton_r      <= ton_w;
            per_r      <= per_w;
            cnt_r      <= 16'h0000;
          end
        end
        ST_ON: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 >= ton_r || ifilt_r >= ocp_r || !run) begin
            st_r       <= ST_OFF;
            gate_drive <= 1'b0;
            off_r      <= 16'h0000;
            dmg_r      <= 1'b0;
            to_r       <= 16'h0000;
          end
        end
        ST_OFF: begin
          cnt_r <= cnt_r + 16'h0001;
          off_r <= off_r + 16'h0001;
          if (demag_q) dmg_r <= 1'b1;
          // The valley timeout runs from demagnetisation, even if that comes before the wait.
          if (dmg_r) to_r <= to_r + 16'h0001;
          if (cnt_r + 16'h0001 >= per_r && off_r + 16'h0001 >= toff_r) begin
            if (wait_v) begin
              st_r <= ST_WAIT;
            end else if (go) begin
              st_r       <= ST_ON;
              gate_drive <= 1'b1;
              ton_r      <= ton_w;
              per_r      <= per_w;
              cnt_r      <= 16'h0000;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          if (demag_q) dmg_r <= 1'b1;
          if (dmg_r) to_r <= to_r + 16'h0001;
          if (!run) begin
            st_r <= ST_IDLE;
          end else if (valley || vto) begin
            dmg_r <= 1'b0;
            if (go) begin
              st_r       <= ST_ON;
              gate_drive <= 1'b1;
              ton_r      <= ton_w;
              per_r      <= per_w;
              cnt_r      <= 16'h0000;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: begin
          st_r       <= ST_IDLE;
          gate_drive <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** psr_pfc_ctrl_asserts.sv ***
// Checker for the boost-switch controller, bound to its top module.
// Assumes the register header is on the include path and one clock domain.
`timescale 1ns/100ps
`include "psr_regs.vh"
module psr_pfc_ctrl_asserts #(
  parameter LOOP_DIV = 200
) (
  input wire        clk,
  input wire        rst,
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire [11:0] boost_voltage_sense,
  input wire [11:0] switch_current_sense,
  input wire [11:0] sine_ref,
  input wire        demag_pin,
  input wire        switch_drain_sense,
  input wire        chip_supply_pin,
  input wire        llc_burst,
  input wire        llc_switching,
  input wire [7:0]  llc_duty,
  input wire        gate_drive,
  input wire        supply_source_en,
  input wire        burst_state
);
  logic [15:0] ctrl_r, toff_r, fmax_r, fabs_r, burst_r, off_r, per_r;
  logic [3:0]  zero_r;
  logic        gate_q_r;
  wire  [15:0] per_lim  = ((fmax_r > fabs_r) ? fmax_r : fabs_r) - 16'h1;
  wire  [8:0]  exit_lvl = {1'b0, burst_r[7:0]} + {1'b0, burst_r[15:8]};
  wire         gate_up  = gate_drive & ~gate_q_r;
  // ************************
  // Shadow settings and interval counters
  // ************************
  // Counters saturate, so the first pulse after reset never looks too early.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= `PSR_RST_CTRL;
      toff_r   <= `PSR_RST_TOFF;
      fmax_r   <= `PSR_RST_FMAX;
      fabs_r   <= `PSR_RST_FABS;
      burst_r  <= `PSR_RST_BURST;
      off_r    <= 16'hffff;
      per_r    <= 16'hffff;
      zero_r   <= 4'h0;
      gate_q_r <= 1'b0;
    end else begin
      if (wr && addr == `PSR_A_CTRL) ctrl_r <= wdata;
      if (wr && addr == `PSR_A_TOFF) toff_r <= wdata;
      if (wr && addr == `PSR_A_FMAX) fmax_r <= wdata;
      if (wr && addr == `PSR_A_FABS) fabs_r <= wdata;
      if (wr && addr == `PSR_A_BURST) burst_r <= wdata;
      gate_q_r <= gate_drive;
      off_r    <= gate_drive ? 16'h0 : off_r + {15'h0, off_r != 16'hffff};
      per_r    <= gate_up ? 16'h0 : per_r + {15'h0, per_r != 16'hffff};
      zero_r   <= (sine_ref != 12'h0) ? 4'h0 : zero_r + {3'h0, zero_r != 4'hf};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (rdata != 16'h0 |-> $past(rd))
    else $error("read data outside its slot");
  a_toff_readback: assert property (rd && addr == `PSR_A_TOFF |=> rdata == toff_r)
    else $error("off-time setting not read back");
  a_enable_gate: assert property (gate_up |-> $past(ctrl_r[0]))
    else $error("switching while disabled");
  a_zero_demand: assert property (zero_r == 4'hf |-> !gate_up)
    else $error("switching with zero demand");
  a_min_off: assert property (gate_up |-> off_r >= toff_r)
    else $error("off-time below minimum");
  a_period_limit: assert property (gate_up |-> per_r >= per_lim)
    else $error("period below frequency limit");
  a_burst_entry: assert property ($rose(burst_state) |-> $past(llc_burst) && $past(llc_duty) < burst_r[7:0])
    else $error("burst entered without cause");
  a_burst_enter_now: assert property (!burst_state && llc_burst && llc_duty < burst_r[7:0] |=> burst_state)
    else $error("burst not entered");
  a_burst_exit: assert property ($fell(burst_state) |-> !$past(llc_burst) || {1'b0, $past(llc_duty)} > exit_lvl)
    else $error("burst left without cause");
  a_supply_stop: assert property (burst_state && gate_drive && $rose(chip_supply_pin) |-> ##[1:8] supply_source_en)
    else $error("low supply did not stop switching");
  a_nonop_quiet: assert property (supply_source_en |=> !gate_drive)
    else $error("gate active while non-operating");
  c_switching: cover property (gate_up);
  c_burst: cover property ($rose(burst_state));
  c_nonop: cover property ($rose(supply_source_en));
endmodule
bind psr_pfc_ctrl psr_pfc_ctrl_asserts #(.LOOP_DIV(LOOP_DIV)) psr_pfc_ctrl_asserts_i (.clk, .rst,
  .addr, .wdata, .wr, .rd, .rdata, .boost_voltage_sense, .switch_current_sense, .sine_ref,
  .demag_pin, .switch_drain_sense, .chip_supply_pin, .llc_burst, .llc_switching, .llc_duty,
  .gate_drive, .supply_source_en, .burst_state);

// *** psr_boost_stage.sv ***
// Behavioural boost stage: switch current ramp, demagnetisation flag and a
// ringing drain comparator. Assumes it shares clk and rst with the controller.
`timescale 1ns/100ps
module psr_boost_stage (
  input  wire         clk,
  input  wire         rst,
  input  wire         gate_drive,
  input  wire  [11:0] vset,
  input  wire         valley_off,
  output logic [11:0] boost_voltage_sense,
  output logic [11:0] switch_current_sense,
  output logic        demag_pin,
  output logic        switch_drain_sense
);
  logic [7:0] ring_r;
  // ************************
  // Inductor and drain behaviour
  // ************************
  // The drain rings with a 32-cycle period once demagnetised; valley_off models
  // ringing too weak to detect, which is when the controller must time out.
  assign boost_voltage_sense = vset;
  assign switch_drain_sense  = demag_pin & ~valley_off & ring_r[4];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_current_sense <= 12'h000;
      demag_pin            <= 1'b1;
      ring_r               <= 8'h00;
    end else if (gate_drive) begin
      switch_current_sense <= (switch_current_sense > 12'hffd) ? 12'hfff : switch_current_sense + 12'h002;
      demag_pin            <= 1'b0;
      ring_r               <= 8'h00;
    end else if (switch_current_sense != 12'h000) begin
      switch_current_sense <= (switch_current_sense > 12'h010) ? switch_current_sense - 12'h010 : 12'h000;
    end else begin
      demag_pin <= 1'b1;
      ring_r    <= ring_r + 8'h01;
    end
  end
endmodule

// *** psr_pfc_ctrl_bench.sv ***
// Self-checking bench for the boost-switch controller: registers, frequency
// limits, modes, valley timeout, burst and low supply. Needs the stage model.
`timescale 1ns/100ps
`include "psr_regs.vh"
module psr_pfc_ctrl_bench;
  logic        clk, rst, wr, rd, llc_burst, llc_switching, chip_supply_pin, valley_off;
  logic        demag_pin, switch_drain_sense, gate_drive, supply_source_en, burst_state;
  logic        gate_q, dem_q;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic [11:0] sine_ref, vset, boost_voltage_sense, switch_current_sense;
  logic [7:0]  llc_duty;
  int          n_mismatch = 0, check_count = 0, cyc = 0, n_rise = 0;
  int          t_rise = 0, t_dem = 0, per = 0, ton = 0, ton1, dwait = 0, base;
  logic [15:0] rst_tab [0:15] = '{`PSR_RST_CTRL, `PSR_RST_FMIN, `PSR_RST_FMAX, `PSR_RST_FABS,
    `PSR_RST_TOFF, `PSR_RST_JIT, `PSR_RST_VREF, `PSR_RST_RC, `PSR_RST_BURST, `PSR_RST_RIPPLE,
    `PSR_RST_RAMP, `PSR_RST_CCM, `PSR_RST_OCP, 16'h0001, 16'h0000, 16'h0000};
  psr_pfc_ctrl #(.LOOP_DIV(4)) psr_pfc_ctrl_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .boost_voltage_sense, .switch_current_sense, .sine_ref, .demag_pin, .switch_drain_sense,
    .chip_supply_pin, .llc_burst, .llc_switching, .llc_duty, .gate_drive, .supply_source_en,
    .burst_state);
  psr_boost_stage psr_boost_stage_i (.clk, .rst, .gate_drive, .vset, .valley_off,
    .boost_voltage_sense, .switch_current_sense, .demag_pin, .switch_drain_sense);
  always #2.5 clk = ~clk;
  // ************************
  // Pulse timing monitor
  // ************************
  always @(posedge clk) begin
    cyc++;
    gate_q <= gate_drive;
    dem_q  <= demag_pin;
    if (demag_pin && !dem_q) t_dem = cyc;
    if (gate_drive && !gate_q) begin
      n_rise++;
      per    = cyc - t_rise;
      dwait  = cyc - t_dem;
      t_rise = cyc;
    end
    if (!gate_drive && gate_q) ton = cyc - t_rise;
  end
  // ************************
  // Access and compare tasks
  // ************************
  task automatic fail(input string m);
    n_mismatch++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chk_num(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask
  task automatic wait_rise(input int k);
    base = n_rise;
    for (int i = 0; i < 60000 && n_rise < base + k; i++) @(posedge clk);
    if (n_rise < base + k) fail("no switching");
  endtask
  task automatic burst_step(input logic b, input logic [7:0] d, input logic e);
    llc_burst <= b;
    llc_duty  <= d;
    repeat (4) @(posedge clk);
    chk_flag(burst_state, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail("watchdog expired");
    wrap_up;
  end
  initial begin
    {clk, wr, rd, llc_burst, llc_switching, chip_supply_pin, valley_off} = 7'h0;
    {addr, wdata, sine_ref, llc_duty} = 40'h0;
    rst  = 1'b1;
    vset = 12'h800;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) if (i != 14) rd_chk(4'(i), rst_tab[i]);
    wr_reg(`PSR_A_STATUS, 16'hffff);
    rd_chk(`PSR_A_STATUS, 16'h0001);
    wr_reg(`PSR_A_FABS, 16'h0500);
    rd_chk(`PSR_A_FABS, 16'h0500);
    wr_reg(`PSR_A_CTRL, 16'h0001);
    repeat (2000) @(posedge clk);
    chk_num(n_rise, 0, 0);
    sine_ref <= 12'hfff;
    wait_rise(2);
    ton1 = ton;
    wait_rise(4);
    chk_num(per, 16'h500, 16'h1388);
    chk_num(ton, ton1, 60000);
    wr_reg(`PSR_A_FMIN, 16'h0800);
    wr_reg(`PSR_A_CTRL, 16'h0005);
    wait_rise(3);
    chk_num(per, 16'h800, 16'h800);
    wr_reg(`PSR_A_CTRL, 16'h0015);
    wait_rise(3);
    chk_num(per, 16'h7f0, 16'h810);
    wr_reg(`PSR_A_FMIN, 16'h0580);
    valley_off <= 1'b1;
    wr_reg(`PSR_A_CTRL, 16'h0003);
    wait_rise(3);
    chk_num(dwait, `PSR_VALLEY_TO_CYC, `PSR_VALLEY_TO_CYC + 10);
    chk_num(per, 16'h581, 60000);
    valley_off <= 1'b0;
    wait_rise(3);
    chk_num(dwait % 32, 16, 26);
    chk_num(dwait, 0, `PSR_VALLEY_TO_CYC - 1);
    wr_reg(`PSR_A_CTRL, 16'h0001);
    llc_switching <= 1'b1;
    burst_step(1'b1, 8'h20, 1'b0);
    burst_step(1'b1, 8'h1f, 1'b1);
    burst_step(1'b1, 8'h28, 1'b1);
    burst_step(1'b1, 8'h29, 1'b0);
    burst_step(1'b1, 8'h1f, 1'b1);
    burst_step(1'b0, 8'h1f, 1'b0);
    burst_step(1'b1, 8'h10, 1'b1);
    vset <= `PSR_RST_VREF;
    repeat (300) @(posedge clk);
    base = n_rise;
    repeat (3000) @(posedge clk);
    chk_num(n_rise - base, 0, 0);
    vset <= `PSR_RST_VREF - `PSR_RST_RIPPLE - 12'h1;
    wait_rise(2);
    chip_supply_pin <= 1'b1;
    repeat (10) @(posedge clk);
    chk_flag(supply_source_en, 1'b1);
    chk_flag(gate_drive, 1'b0);
    chip_supply_pin <= 1'b0;
    repeat (10) @(posedge clk);
    chk_flag(supply_source_en, 1'b0);
    wr_reg(`PSR_A_RIPPLE, 16'h0000);
    vset          <= `PSR_RST_VREF;
    llc_switching <= 1'b0;
    repeat (3000) @(posedge clk);
    base = n_rise;
    repeat (3000) @(posedge clk);
    chk_num(n_rise - base, 0, 0);
    llc_switching <= 1'b1;
    wait_rise(2);
    wrap_up;
  end
endmodule
